// >>> hdl/ebm_defs.svh
// Constant definitions for the endpoint buffer manager.
`ifndef EBM_DEFS_SVH
`define EBM_DEFS_SVH
// ==========================================================================
// Buffer geometry
`define EBM_BUF_BYTES 4'h8
`define EBM_EP_COUNT 16
// ==========================================================================
// APB map (byte addresses)
`define EBM_CFG_BASE 12'h000
`define EBM_CNT_BASE 12'h040
`define EBM_PEND_ADDR 12'h080
`define EBM_DMA_ADDR 12'h084
`define EBM_MEM_BASE 12'h400
`define EBM_REG_MASK 12'hFC0
`define EBM_MEM_MASK 12'hC00
// ==========================================================================
// Endpoint configuration, count and DMA word fields
`define EBM_B_EN 0
`define EBM_B_DBL 1
`define EBM_B_IE 2
`define EBM_B_TOG 3
`define EBM_B_STALL 4
`define EBM_B_HOLDX 5
`define EBM_B_HOLDY 6
`define EBM_TYPE_LO 7
`define EBM_TYPE_ISO 2'h2
`define EBM_CFG_RESET 9'h060
`define EBM_CNT_YLO 8
`define EBM_DMA_CH 4
`define EBM_DMA_W 5
`endif

// >>> hdl/ebm_pkg.sv
// Types shared by the endpoint buffer manager.
package ebm_pkg;
    // ======================================================================
    // Transaction engine states, Gray coded along IDLE-RX and TX-WAIT-IDLE.
    typedef enum logic [1:0] {
        EBM_IDLE = 2'h0,
        EBM_RX = 2'h1,
        EBM_TX = 2'h3,
        EBM_WAIT = 2'h2
    } ebm_state_t;
    // Handshake codes handed to the serial engine.
    typedef enum logic [1:0] {
        EBM_HS_ACK = 2'h0,
        EBM_HS_NAK = 2'h1,
        EBM_HS_STALL = 2'h2
    } ebm_hs_t;
endpackage

// >>> hdl/ebm_usb_buffer_manager.sv
// Endpoint buffer manager: USB transaction engine, buffers and APB registers.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "ebm_defs.svh"
module ebm_usb_buffer_manager
    import ebm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tok_valid,
    input wire logic tok_in,
    input wire logic [2:0] tok_ep,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_end,
    input wire logic rx_err,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    output logic tx_last,
    output logic tx_empty,
    input wire logic tx_ready,
    input wire logic host_ack,
    input wire logic host_timeout,
    output logic hs_valid,
    output logic [1:0] hs_code,
    output logic ep_irq,
    output logic [3:0] dma_ch_active
);
    // ======================================================================
    // Helpers
    // Isochronous type check.
    function automatic logic is_iso(input logic [8:0] c);
        is_iso = (c[`EBM_TYPE_LO +: 2] == `EBM_TYPE_ISO);
    endfunction
    // Buffer pick: double buffered (or isochronous) endpoints follow the toggle.
    function automatic logic sel_buf(input logic [8:0] c);
        sel_buf = (c[`EBM_B_DBL] | is_iso(c)) & c[`EBM_B_TOG];
    endfunction
    // Hold flag of the chosen buffer.
    function automatic logic hold_of(input logic [8:0] c, input logic xy);
        hold_of = xy ? c[`EBM_B_HOLDY] : c[`EBM_B_HOLDX];
    endfunction
    // Sets the chosen hold flag and inverts the toggle after a completed transaction.
    function automatic logic [8:0] finish(input logic [8:0] c, input logic xy);
        logic [8:0] r;
        r = c;
        r[`EBM_B_TOG] = ~c[`EBM_B_TOG];
        if (xy) begin
            r[`EBM_B_HOLDY] = 1'b1;
        end else begin
            r[`EBM_B_HOLDX] = 1'b1;
        end
        finish = r;
    endfunction

    // ======================================================================
    // State
    logic [8:0] cfg_r [`EBM_EP_COUNT];
    logic [8:0] cfg_nxt [`EBM_EP_COUNT];
    logic [3:0] cnt_r [`EBM_EP_COUNT][2];
    logic [3:0] cnt_nxt [`EBM_EP_COUNT][2];
    logic [7:0] mem [256];
    logic [15:0] pend_r, pend_nxt;
    logic [19:0] dma_r, dma_nxt;
    ebm_state_t st_r, st_nxt;
    logic [3:0] ep_r, ep_nxt;
    logic xy_r, xy_nxt;
    logic ok_r, ok_nxt;
    logic [3:0] bidx_r, bidx_nxt;
    logic [3:0] tcnt_r, tcnt_nxt;
    logic [7:0] tx_byte_r, tx_byte_nxt;
    logic tx_last_r, tx_last_nxt;
    logic tx_empty_r, tx_empty_nxt;
    logic hs_valid_r, hs_valid_nxt;
    logic [1:0] hs_code_r, hs_code_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic perr_r, perr_nxt;
    logic mwe;
    logic [7:0] maddr;
    logic [7:0] mdata;
    logic wr, rd_setup;
    logic [3:0] tep;
    logic [8:0] tc;
    logic txy;

    assign wr = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign tep = {tok_in, tok_ep};

    // ======================================================================
    // Next-state logic for registers, transaction engine and APB answers.
    always_comb begin
        cfg_nxt = cfg_r;
        cnt_nxt = cnt_r;
        pend_nxt = pend_r;
        dma_nxt = dma_r;
        st_nxt = st_r;
        ep_nxt = ep_r;
        xy_nxt = xy_r;
        ok_nxt = ok_r;
        bidx_nxt = bidx_r;
        tcnt_nxt = tcnt_r;
        tx_byte_nxt = tx_byte_r;
        tx_last_nxt = tx_last_r;
        tx_empty_nxt = tx_empty_r;
        hs_valid_nxt = 1'b0;
        hs_code_nxt = hs_code_r;
        prdata_nxt = prdata_r;
        perr_nxt = perr_r;
        mwe = 1'b0;
        maddr = paddr[9:2];
        mdata = pwdata[7:0];
        tc = 9'h000;
        txy = 1'b0;
        // Firmware writes land first so that a hardware update in the same
        // cycle overrides them; a set never gets lost to a clear.
        if (wr) begin
            if ((paddr & `EBM_REG_MASK) == `EBM_CFG_BASE) begin
                cfg_nxt[paddr[5:2]] = pwdata[8:0];
            end else if ((paddr & `EBM_REG_MASK) == `EBM_CNT_BASE) begin
                cnt_nxt[paddr[5:2]][0] = pwdata[3:0];
                cnt_nxt[paddr[5:2]][1] = pwdata[`EBM_CNT_YLO +: 4];
            end else if (paddr == `EBM_PEND_ADDR) begin
                pend_nxt = pend_r & ~pwdata[15:0];
            end else if (paddr == `EBM_DMA_ADDR) begin
                dma_nxt = pwdata[19:0];
            end else if ((paddr & `EBM_MEM_MASK) == `EBM_MEM_BASE) begin
                mwe = 1'b1;
            end
        end
        case (st_r)
            EBM_IDLE: begin
                tc = cfg_nxt[tep];
                txy = sel_buf(tc);
                // Endpoint 0 and disabled endpoints are not served here.
                if (tok_valid && tok_ep != 3'h0 && tc[`EBM_B_EN]) begin
                    ep_nxt = tep;
                    xy_nxt = txy;
                    bidx_nxt = 4'h0;
                    ok_nxt = ~tc[`EBM_B_STALL] & ~hold_of(tc, txy);
                    hs_code_nxt = tc[`EBM_B_STALL] ? EBM_HS_STALL : EBM_HS_NAK;
                    if (!tok_in) begin
                        st_nxt = EBM_RX;
                    end else if (!tc[`EBM_B_STALL] && (!hold_of(tc, txy) || is_iso(tc))) begin
                        // An isochronous buffer still on hold goes out as a null packet.
                        tcnt_nxt = hold_of(tc, txy) ? 4'h0 : cnt_nxt[tep][txy];
                        tx_byte_nxt = mem[{tep, txy, 3'h0}];
                        tx_last_nxt = (tcnt_nxt <= 4'h1);
                        tx_empty_nxt = (tcnt_nxt == 4'h0);
                        st_nxt = EBM_TX;
                    end else begin
                        hs_valid_nxt = 1'b1;
                    end
                end
            end
            EBM_RX: begin
                // Bytes beyond the buffer are dropped rather than wrapping.
                if (rx_valid && ok_r && bidx_r < `EBM_BUF_BYTES) begin
                    mwe = 1'b1;
                    maddr = {ep_r, xy_r, bidx_r[2:0]};
                    mdata = rx_byte;
                    bidx_nxt = bidx_r + 4'h1;
                end
                if (rx_end) begin
                    st_nxt = EBM_IDLE;
                    if (!rx_err) begin
                        hs_valid_nxt = ~is_iso(cfg_nxt[ep_r]);
                        if (ok_r) begin
                            cnt_nxt[ep_r][xy_r] = bidx_r;
                            cfg_nxt[ep_r] = finish(cfg_nxt[ep_r], xy_r);
                            pend_nxt[ep_r] = ~is_iso(cfg_nxt[ep_r]);
                            hs_code_nxt = EBM_HS_ACK;
                        end
                    end
                end
            end
            EBM_TX: begin
                if (tx_ready) begin
                    if (tx_last_r) begin
                        if (is_iso(cfg_nxt[ep_r])) begin
                            // No handshake follows an isochronous packet.
                            cfg_nxt[ep_r] = finish(cfg_nxt[ep_r], xy_r);
                            st_nxt = EBM_IDLE;
                        end else begin
                            st_nxt = EBM_WAIT;
                        end
                    end else begin
                        bidx_nxt = bidx_r + 4'h1;
                        tx_byte_nxt = mem[{ep_r, xy_r, bidx_nxt[2:0]}];
                        tx_last_nxt = (bidx_nxt + 4'h1 >= tcnt_r);
                    end
                end
            end
            EBM_WAIT: begin
                if (host_ack) begin
                    cfg_nxt[ep_r] = finish(cfg_nxt[ep_r], xy_r);
                    pend_nxt[ep_r] = 1'b1;
                    st_nxt = EBM_IDLE;
                end else if (host_timeout) begin
                    st_nxt = EBM_IDLE;
                end
            end
            default: begin
                st_nxt = EBM_IDLE;
            end
        endcase
        // Read data is fetched in the setup phase so it leaves a flip-flop.
        if (rd_setup) begin
            prdata_nxt = 32'h0000_0000;
            perr_nxt = 1'b0;
            if ((paddr & `EBM_REG_MASK) == `EBM_CFG_BASE) begin
                prdata_nxt[8:0] = cfg_r[paddr[5:2]];
            end else if ((paddr & `EBM_REG_MASK) == `EBM_CNT_BASE) begin
                prdata_nxt[3:0] = cnt_r[paddr[5:2]][0];
                prdata_nxt[`EBM_CNT_YLO +: 4] = cnt_r[paddr[5:2]][1];
            end else if (paddr == `EBM_PEND_ADDR) begin
                prdata_nxt[15:0] = pend_r;
            end else if (paddr == `EBM_DMA_ADDR) begin
                prdata_nxt[19:0] = dma_r;
            end else if ((paddr & `EBM_MEM_MASK) == `EBM_MEM_BASE) begin
                prdata_nxt[7:0] = mem[paddr[9:2]];
            end else begin
                // Unmapped writes are dropped silently; only a read reports an error.
                perr_nxt = ~pwrite;
            end
        end
    end

    // ======================================================================
    // Registers. A firmware buffer write that collides with a received byte
    // loses; firmware should not touch a buffer whose hold flag is clear.
    always_ff @(posedge core_clk) begin
        if (mwe) begin
            mem[maddr] <= mdata;
        end
        if (rst) begin
            for (int i = 0; i < `EBM_EP_COUNT; i++) begin
                cfg_r[i] <= `EBM_CFG_RESET;
                cnt_r[i][0] <= 4'h0;
                cnt_r[i][1] <= 4'h0;
            end
            pend_r <= 16'h0000;
            dma_r <= 20'h00000;
            st_r <= EBM_IDLE;
            ep_r <= 4'h0;
            xy_r <= 1'b0;
            ok_r <= 1'b0;
            bidx_r <= 4'h0;
            tcnt_r <= 4'h0;
            tx_byte_r <= 8'h00;
            tx_last_r <= 1'b0;
            tx_empty_r <= 1'b0;
            hs_valid_r <= 1'b0;
            hs_code_r <= 2'h0;
            prdata_r <= 32'h0000_0000;
            perr_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            cnt_r <= cnt_nxt;
            pend_r <= pend_nxt;
            dma_r <= dma_nxt;
            st_r <= st_nxt;
            ep_r <= ep_nxt;
            xy_r <= xy_nxt;
            ok_r <= ok_nxt;
            bidx_r <= bidx_nxt;
            tcnt_r <= tcnt_nxt;
            tx_byte_r <= tx_byte_nxt;
            tx_last_r <= tx_last_nxt;
            tx_empty_r <= tx_empty_nxt;
            hs_valid_r <= hs_valid_nxt;
            hs_code_r <= hs_code_nxt;
            prdata_r <= prdata_nxt;
            perr_r <= perr_nxt;
        end
    end

    // ======================================================================
    // Outputs: enabled pending flags, and enabled DMA channels bound to iso endpoints.
    always_comb begin
        ep_irq = 1'b0;
        for (int i = 0; i < `EBM_EP_COUNT; i++) begin
            ep_irq = ep_irq | (pend_r[i] & cfg_r[i][`EBM_B_IE]);
        end
        for (int k = 0; k < `EBM_DMA_CH; k++) begin
            dma_ch_active[k] = dma_r[k * `EBM_DMA_W + 4] &
                is_iso(cfg_r[dma_r[k * `EBM_DMA_W +: 4]]);
        end
    end

    assign pready = psel & penable;
    assign pslverr = psel & penable & perr_r;
    assign prdata = prdata_r;
    assign tx_valid = (st_r == EBM_TX);
    assign tx_byte = tx_byte_r;
    assign tx_last = tx_last_r;
    assign tx_empty = tx_empty_r;
    assign hs_valid = hs_valid_r;
    assign hs_code = hs_code_r;
endmodule

// >>> dv/ebm_usb_buffer_manager_props.sv
// Port-level checker for the endpoint buffer manager.
`timescale 1ns/1ns
module ebm_bm_props (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tok_valid,
    input wire logic tok_in,
    input wire logic rx_end,
    input wire logic rx_err,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_last,
    input wire logic tx_ready,
    input wire logic host_ack,
    input wire logic host_timeout,
    input wire logic hs_valid,
    input wire logic [1:0] hs_code,
    input wire logic ep_irq
);
    // ==========
    // APB error, handshake, transmit and interrupt relations, all in the core clock domain.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    err_read_only_a: assert property (pslverr |-> pready && !pwrite) else $error("slave error on a write");
    crc_silent_a: assert property (rx_end && rx_err |=> !hs_valid [*2]) else $error("answer to bad packet");
    hs_cause_a: assert property (hs_valid |-> $past(rx_end) || $past(tok_valid)) else $error("stray answer");
    in_answer_a: assert property (tok_valid && tok_in && !tx_valid |=> hs_valid != tx_valid) else $error("in token");
    in_refuse_a: assert property (hs_valid && tok_in |-> hs_code inside {2'h1, 2'h2}) else $error("in answer code");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte)) else $error("byte dropped");
    tx_end_a: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid) else $error("send past last byte");
    retry_keep_a: assert property (host_timeout |=> $stable(ep_irq) [*2]) else $error("irq moved on timeout");
    out_ack_irq_a: assert property (hs_valid && hs_code == 2'h0 |-> ##[0:1] ep_irq) else $error("no irq on ack");
    in_ack_irq_a: assert property (host_ack && !tx_valid |-> ##[1:2] ep_irq) else $error("no irq on host ack");
    irq_stays_a: assert property (ep_irq && !(psel && penable && pwrite) |=> ep_irq) else $error("irq lost");
    cover property (hs_valid && hs_code == 2'h2);
    cover property (host_timeout);
    cover property (tx_valid && !tx_ready);
endmodule
bind ebm_usb_buffer_manager ebm_bm_props u_props (.core_clk, .rst, .psel, .penable, .pwrite, .pready, .pslverr,
    .tok_valid, .tok_in, .rx_end, .rx_err, .tx_valid, .tx_byte, .tx_last, .tx_ready, .host_ack, .host_timeout,
    .hs_valid, .hs_code, .ep_irq);

// >>> dv/ebm_host_model.sv
// Host and serial engine model at the USB side of the buffer manager.
`timescale 1ns/1ns
module ebm_host_model (
    input wire logic core_clk,
    output logic tok_valid,
    output logic tok_in,
    output logic [2:0] tok_ep,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_end,
    output logic rx_err,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_last,
    input wire logic tx_empty,
    output logic tx_ready,
    output logic host_ack,
    output logic host_timeout,
    input wire logic hs_valid,
    input wire logic [1:0] hs_code
);
    logic hs_seen;
    logic [1:0] hs_r;
    // ==========
    // Idle levels and handshake capture; each token clears the capture.
    initial begin
        {tok_valid, tok_in, tok_ep, rx_valid, rx_byte, rx_end, rx_err, tx_ready, host_ack, host_timeout} = '0;
        hs_seen = 1'b0;
    end
    always @(posedge core_clk) begin
        if (hs_valid) begin
            hs_seen <= 1'b1;
            hs_r <= hs_code;
        end
    end
    task automatic token(input logic in, input logic [2:0] ep);
        {tok_valid, tok_in, tok_ep, hs_seen} <= {1'b1, in, ep, 1'b0};
        @(posedge core_clk);
        tok_valid <= 1'b0;
    endtask
    // The data line shows the inverse of the last byte once released, so stale data never looks valid.
    task automatic out_pkt(input logic [2:0] ep, input logic [7:0] d[$], input logic err);
        token(1'b0, ep);
        foreach (d[i]) begin
            {rx_valid, rx_byte} <= {1'b1, d[i]};
            @(posedge core_clk);
        end
        {rx_valid, rx_byte, rx_end, rx_err} <= {1'b0, ~rx_byte, 1'b1, err};
        @(posedge core_clk);
        {rx_end, rx_err} <= 2'b00;
        repeat (3) @(posedge core_clk);
    endtask
    // Ready is random, so the device is stalled now and then in mid-packet.
    task automatic in_tok(input logic [2:0] ep, input logic ack, output logic [7:0] got[$]);
        logic fin;
        logic sent;
        got = {};
        fin = 1'b0;
        sent = 1'b0;
        token(1'b1, ep);
        for (int k = 0; k < 60 && !fin; k++) begin
            tx_ready <= 1'($urandom);
            @(posedge core_clk);
            if (tx_valid && tx_ready) begin
                if (!tx_empty) got.push_back(tx_byte);
                sent = 1'b1;
                fin = tx_last;
            end
            fin = fin || hs_seen;
        end
        {tx_ready, host_ack, host_timeout} <= {1'b0, sent && ack, sent && !ack};
        @(posedge core_clk);
        {host_ack, host_timeout} <= 2'b00;
        repeat (3) @(posedge core_clk);
    endtask
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the endpoint buffer manager.
`timescale 1ns/1ns
`include "ebm_defs.svh"
module testbench;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, tok_valid, tok_in, rx_valid, rx_end, rx_err;
    logic tx_valid, tx_last, tx_empty, tx_ready, host_ack, host_timeout, hs_valid, ep_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] rx_byte, tx_byte;
    logic [2:0] tok_ep;
    logic [1:0] hs_code;
    logic [3:0] dma_ch_active;
    int mismatches, n_compared, cyc, pend_m;
    int cfg_m[16], cnt_m[16];
    logic [7:0] mem_m[16][2][8];
    ebm_usb_buffer_manager uut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .tok_valid, .tok_in, .tok_ep, .rx_valid, .rx_byte, .rx_end, .rx_err, .tx_valid, .tx_byte,
        .tx_last, .tx_empty, .tx_ready, .host_ack, .host_timeout, .hs_valid, .hs_code, .ep_irq, .dma_ch_active);
    ebm_host_model host (.core_clk, .tok_valid, .tok_in, .tok_ep, .rx_valid, .rx_byte, .rx_end, .rx_err, .tx_valid,
        .tx_byte, .tx_last, .tx_empty, .tx_ready, .host_ack, .host_timeout, .hs_valid, .hs_code);
    // ==========
    // Clock, and a cycle ceiling well above the several hundred cycles the sequence needs.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // APB master: the request holds until pready is seen at an edge; q carries pslverr over read data.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] q);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = {pslverr, prdata};
        {psel, penable} <= 2'b00;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [11:0] a, input int v);
        logic [32:0] q;
        apb(1'b1, a, v, q);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] exp);
        logic [32:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    // Reference model: buffer select, expected answer, and the update after a completed transfer.
    function automatic int sel(int e);
        return (cfg_m[e][1] || cfg_m[e][8:7] == 2) ? cfg_m[e][3] : 0;
    endfunction
    function automatic int exp_hs(int e);
        if (cfg_m[e][8:7] == 2) return 3;
        if (cfg_m[e][4]) return 2;
        return cfg_m[e][5 + sel(e)];
    endfunction
    function automatic void done(int e);
        cfg_m[e][5 + sel(e)] = 1'b1;
        cfg_m[e][3] = !cfg_m[e][3];
        if (cfg_m[e][8:7] != 2) pend_m[e] = 1'b1;
    endfunction
    function automatic logic irq_m();
        for (int e = 0; e < 16; e++)
            if (pend_m[e] && cfg_m[e][2]) return 1'b1;
        return 1'b0;
    endfunction
    task automatic setcfg(input int e, input int v);
        cfg_m[e] = v;
        wr(`EBM_CFG_BASE + 12'(4 * e), v);
        wr(`EBM_CNT_BASE + 12'(4 * e), cnt_m[e]);
    endtask
    task automatic fill(input int e, input int s, input int n);
        for (int b = 0; b < n; b++) begin
            mem_m[e][s][b] = 8'($urandom);
            wr(`EBM_MEM_BASE + 12'(64 * e + 32 * s + 4 * b), mem_m[e][s][b]);
        end
        cnt_m[e][s * 8 +: 4] = 4'(n);
        wr(`EBM_CNT_BASE + 12'(4 * e), cnt_m[e]);
    endtask
    task automatic check_ep(input int e);
        rd(`EBM_CFG_BASE + 12'(4 * e), cfg_m[e]);
        rd(`EBM_CNT_BASE + 12'(4 * e), cnt_m[e]);
        for (int s = 0; s < 2; s++)
            for (int b = 0; b < cnt_m[e][s * 8 +: 4]; b++)
                rd(`EBM_MEM_BASE + 12'(64 * e + 32 * s + 4 * b), mem_m[e][s][b]);
        chk(ep_irq, irq_m());
    endtask
    task automatic do_out(input int e, input int n, input logic err);
        logic [7:0] d[$];
        int h;
        logic ok;
        h = err ? 3 : exp_hs(e);
        ok = !cfg_m[e][4] && !cfg_m[e][5 + sel(e)];
        repeat (n) d.push_back(8'($urandom));
        host.out_pkt(3'(e), d, err);
        chk(host.hs_seen ? host.hs_r : 3, h);
        // A packet that is taken streams into the buffer even when its check fails later.
        if (ok) foreach (d[i]) mem_m[e][sel(e)][i] = d[i];
        if (ok && !err) begin
            cnt_m[e][sel(e) * 8 +: 4] = 4'(n);
            done(e);
        end
        check_ep(e);
    endtask
    task automatic do_in(input int e, input logic ack);
        logic [7:0] got[$];
        int h, s;
        h = exp_hs(e);
        s = sel(e);
        host.in_tok(3'(e), ack, got);
        chk(host.hs_seen ? host.hs_r : 3, h == 0 ? 3 : h);
        if (h == 0) begin
            chk(got.size(), cnt_m[e][s * 8 +: 4]);
            foreach (got[i]) chk(got[i], mem_m[e][s][i]);
            if (ack) done(e);
        end
        // An isochronous buffer on hold goes out as a null packet and closes with no handshake.
        if (h == 3 && !cfg_m[e][4]) begin
            chk(got.size(), cfg_m[e][5 + s] ? 0 : cnt_m[e][s * 8 +: 4]);
            done(e);
        end
        check_ep(e);
    endtask
    // Main sequence: out, refusal and error cases, double and iso buffers, then in traffic.
    initial begin
        void'($urandom(54));
        {psel, penable, pwrite, paddr, pwdata} = '0;
        rst = 1'b1;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        for (int e = 0; e < 16; e++) begin
            cfg_m[e] = `EBM_CFG_RESET;
            rd(`EBM_CFG_BASE + 12'(4 * e), cfg_m[e]);
        end
        setcfg(1, 9'h085);
        do_out(1, 5, 1'b0);
        do_out(1, 3, 1'b0);
        wr(`EBM_PEND_ADDR, 32'h2);
        pend_m = 0;
        setcfg(1, cfg_m[1] & 32'h19F);
        do_out(1, 8, 1'b1);
        setcfg(1, cfg_m[1] | 32'h10);
        do_out(1, 2, 1'b0);
        setcfg(2, 9'h007);
        do_out(2, 4, 1'b0);
        do_out(2, 6, 1'b0);
        do_out(2, 1, 1'b0);
        wr(`EBM_PEND_ADDR, 32'hFFFF);
        pend_m = 0;
        setcfg(3, 9'h105);
        do_out(3, 7, 1'b0);
        do_out(3, 2, 1'b0);
        wr(`EBM_DMA_ADDR, 32'h13);
        chk(dma_ch_active, 4'h1);
        setcfg(9, 9'h0E5);
        do_in(9, 1'b0);
        fill(9, 0, 6);
        setcfg(9, 9'h085);
        do_in(9, 1'b0);
        do_in(9, 1'b1);
        setcfg(9, cfg_m[9] | 32'h10);
        do_in(9, 1'b1);
        setcfg(10, 9'h08F);
        fill(10, 1, 8);
        do_in(10, 1'b1);
        setcfg(11, 9'h165);
        do_in(11, 1'b0);
        rd(12'h100, 33'h100000000);
        wrap_up();
    end
endmodule
